// file: sspwm_channel.sv
// on/off decision of one channel for the current grayscale period
`timescale 1ns/100ps
`include "sspwm_defines.svh"

module sspwm_channel (
  // grayscale value and shared counter
  input  wire logic [`SSPWM_GS_W-1:0] i_value,
  input  wire logic [`SSPWM_GS_W-1:0] i_index,
  input  wire logic                   i_spread,
  // decision
  output wire logic                   o_on
);

  // reverse the segment number: rank of a segment in the extra order
  function automatic logic [`SSPWM_SEG_W-1:0] sspwm_rank(input logic [`SSPWM_SEG_W-1:0] seg);
    logic [`SSPWM_SEG_W-1:0] r;
    r = '0;
    for (int b = 0; b < `SSPWM_SEG_W; b++)
      r[b] = seg[`SSPWM_SEG_W-1-b];
    return r;
  endfunction

  logic [`SSPWM_SEG_W-1:0] seg;
  logic [`SSPWM_POS_W-1:0] pos;
  logic [`SSPWM_POS_W-1:0] base;
  logic [`SSPWM_SEG_W-1:0] extra;
  logic [`SSPWM_POS_W:0]   width;
  logic                    spread_on;
  logic                    plain_on;

  // segment of 128 periods and position inside it
  assign seg   = i_index[`SSPWM_SEG_MSB:`SSPWM_SEG_LSB];
  assign pos   = i_index[`SSPWM_POS_W-1:0];
  // every segment gets value/32, first value%32 ranks get one more
  assign base  = i_value[`SSPWM_BASE_MSB:`SSPWM_BASE_LSB];
  assign extra = i_value[`SSPWM_EXTRA_MSB:0];
  assign width = {1'b0, base} + {7'h00, (sspwm_rank(seg) < extra)};
  // on-periods contiguous from segment start, never above 128
  assign spread_on = {1'b0, pos} < width;
  assign plain_on  = i_index < i_value;
  assign o_on      = i_spread ? spread_on : plain_on;
endmodule

// file: sspwm_checker.sv
// port assertions of the spread-spectrum pwm sequencer
`timescale 1ns/100ps
`include "sspwm_defines.svh"
module sspwm_checker #(
  parameter int N_CH = 16
) (
  // watched ports
  input wire logic            i_clk,
  input wire logic            i_rstn,
  input wire logic [7:0]      i_addr,
  input wire logic [31:0]     i_wdata,
  input wire logic            i_wr,
  input wire logic            i_rd,
  input wire logic [31:0]     o_rdata,
  input wire logic            i_grayscale_clock,
  input wire logic [N_CH-1:0] o_channel_sink_output,
  input wire logic            o_period_active
);
  logic [3:0]  ctrl_reg;
  logic [2:0]  sync_reg;
  logic [12:0] cnt_reg;
  // own sync of the pin; one cycle of extra delay is tolerated below
  wire         tick  = sync_reg[1] & ~sync_reg[2];
  wire         end_t = o_period_active & tick & (cnt_reg == 13'h0ffe);
  wire         ld_wr = i_wr & (i_addr == `SSPWM_LOAD_ADDR);
  // control mirror and tick count inside a period
  always_ff @(posedge i_clk)
  begin
    sync_reg <= {sync_reg[1:0], i_grayscale_clock};
    cnt_reg  <= o_period_active ? cnt_reg + {12'h000, tick} : 13'h0000;
    if (!i_rstn)
      ctrl_reg <= `SSPWM_CTRL_RESET;
    else if (i_wr && i_addr == `SSPWM_CTRL_ADDR)
      ctrl_reg <= i_wdata[3:0];
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // reset, bus and period relations
  reset_clear_a: assert property (disable iff (1'b0) !i_rstn |=> o_rdata == '0 && !o_period_active
    && o_channel_sink_output == '0) else $error("outputs not cleared in reset");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == '0) else $error("read data without read");
  ctrl_read_a: assert property (i_rd && i_addr == `SSPWM_CTRL_ADDR |=> o_rdata == {28'h0, ctrl_reg})
    else $error("control readback wrong");
  period_end_a: assert property (end_t |-> ##[1:2] !o_period_active)
    else $error("period not ended at last edge");
  single_stop_a: assert property (end_t && !ctrl_reg[1] |-> ##[1:2] (!o_period_active [*8]))
    else $error("single period restarted");
  repeat_run_a: assert property (end_t && ctrl_reg[1] |-> ##[1:2] !o_period_active ##[1:16] o_period_active)
    else $error("auto repeat did not restart");
  off_hold_a: assert property (ctrl_reg[0] |=> !o_period_active && o_channel_sink_output == '0)
    else $error("outputs active while off");
  load_restart_a: assert property (ld_wr && ctrl_reg[2] && !ctrl_reg[0] |=> !o_period_active
    && o_channel_sink_output == '0) else $error("load did not restart");
  sink_in_run_a: assert property (|o_channel_sink_output |-> o_period_active)
    else $error("sink on outside period");
  start_tick_a: assert property ($rose(o_period_active) |-> $past(tick) || $past(tick, 2))
    else $error("period started without edge");
endmodule
bind sspwm_sequencer sspwm_checker #(.N_CH(N_CH)) u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_grayscale_clock(i_grayscale_clock),
  .o_channel_sink_output(o_channel_sink_output), .o_period_active(o_period_active));

// file: sspwm_defines.svh
// constants of the spread-spectrum grayscale pwm sequencer
// How it works
// - period split into 32 equal segments
// - period spans 4096 grayscale clock edges
// - segment holds at most 128 periods
// - base G/32, extras in bit-reversed order
// - value one lights first segment only
// - value 32 gives one period everywhere
// - value 64 gives two periods everywhere
// - max value: 128 each, 127 last
// - 4094: 127 in segments 16, 32
// - load with timing restart restarts period
// - auto repeat restarts at 4096th edge
// - auto repeat keeps period repeating
// - no repeat runs a single period
// - after single period outputs stay off
// - mode bit selects spread or conventional
// - output-off holds counter zero, outputs off
// - 4096th edge moves first stage onward
// - after restart, count from next edge
`ifndef SSPWM_DEFINES_SVH
`define SSPWM_DEFINES_SVH

// grayscale counter layout
`define SSPWM_GS_W        12
`define SSPWM_SEG_W       5
`define SSPWM_POS_W       7
`define SSPWM_SEG_MSB     11
`define SSPWM_SEG_LSB     7
`define SSPWM_BASE_MSB    11
`define SSPWM_BASE_LSB    5
`define SSPWM_EXTRA_MSB   4
// index held when the 4096th edge arrives; index 4095 is never shown
`define SSPWM_PERIOD_LAST 12'hffe
`define SSPWM_MAX_CH      16

// register bus
`define SSPWM_ADDR_W      8
`define SSPWM_DATA_W      32
`define SSPWM_CTRL_ADDR   8'h00
`define SSPWM_STATUS_ADDR 8'h04
`define SSPWM_LOAD_ADDR   8'h08
`define SSPWM_GS_PAGE     2'h1

// control register fields
`define SSPWM_CTRL_W      4
`define SSPWM_CTRL_OFF    0
`define SSPWM_CTRL_RPT    1
`define SSPWM_CTRL_TMG    2
`define SSPWM_CTRL_SPREAD 3
`define SSPWM_CTRL_RESET  4'h9

// status register fields
`define SSPWM_STAT_EDGE_W 13
`define SSPWM_STAT_RUN    16
`define SSPWM_STAT_ARMED  17

`endif

// file: sspwm_grayscale_clock_model.sv
// grayscale clock source of the display controller
`timescale 1ns/100ps
module sspwm_grayscale_clock_model (
  // clock and control
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic [1:0] i_half,
  // grayscale clock pin
  output logic            o_grayscale_clock
);
  logic [1:0] ph_reg;
  // toggles every i_half cycles; stands low between frames
  always_ff @(posedge i_clk)
  begin
    if (!i_en)
    begin
      ph_reg            <= 2'h0;
      o_grayscale_clock <= 1'b0;
    end
    else if (ph_reg == i_half - 2'h1)
    begin
      ph_reg            <= 2'h0;
      o_grayscale_clock <= ~o_grayscale_clock;
    end
    else
      ph_reg <= ph_reg + 2'h1;
  end
endmodule

// file: sspwm_pkg.sv
// types of the spread-spectrum grayscale pwm sequencer
package sspwm_pkg;

  // sequencer states: idle (off or finished), armed (waits first edge), run
  typedef enum logic [1:0] {
    SSPWM_IDLE,
    SSPWM_ARMED,
    SSPWM_RUN
  } sspwm_state_type;

endpackage

// file: sspwm_sequencer.sv
// spread-spectrum grayscale pwm sequencer with register port
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "sspwm_defines.svh"

module sspwm_sequencer #(
  parameter int N_CH = `SSPWM_MAX_CH
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  // register port
  input  wire logic [`SSPWM_ADDR_W-1:0] i_addr,
  input  wire logic [`SSPWM_DATA_W-1:0] i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [`SSPWM_DATA_W-1:0] o_rdata,
  // grayscale clock pin from the display controller
  input  wire logic                     i_grayscale_clock,
  // sink outputs and period flag
  output logic      [N_CH-1:0]          o_channel_sink_output,
  output logic                          o_period_active
);

  localparam int CH_W = 4;

  // refuse channel counts the address map cannot hold
  generate
    if (N_CH < 1 || N_CH > `SSPWM_MAX_CH)
    begin : g_bad_n_ch
      $error("sspwm_sequencer: N_CH must lie in 1..16");
    end
  endgenerate

  // pin synchroniser and edge history
  logic                         gclk_meta_reg;
  logic                         gclk_sync_reg;
  logic                         gclk_prev_reg;
  logic                         gs_tick;

  // control and data storage
  logic [`SSPWM_CTRL_W-1:0]     ctrl_reg;
  logic [`SSPWM_CTRL_W-1:0]     ctrl_next;
  logic [`SSPWM_GS_W-1:0]       gs1_reg [N_CH];
  logic [`SSPWM_GS_W-1:0]       gs2_reg [N_CH];
  logic [`SSPWM_DATA_W-1:0]     rdata_reg;
  logic [`SSPWM_DATA_W-1:0]     rdata_next;

  // sequencer
  sspwm_pkg::sspwm_state_type   state_reg;
  sspwm_pkg::sspwm_state_type   state_next;
  logic [`SSPWM_GS_W-1:0]       idx_reg;
  logic [`SSPWM_GS_W-1:0]       idx_next;
  logic [N_CH-1:0]              sink_reg;
  logic [N_CH-1:0]              sink_next;
  logic [N_CH-1:0]              chan_on;
  logic                         active_reg;

  // decode wires
  logic                         ctrl_sel;
  logic                         status_sel;
  logic                         load_sel;
  logic                         gs_sel;
  logic [CH_W-1:0]              gs_idx;
  logic                         ctrl_wr;
  logic                         load_wr;
  logic                         gs_wr;

  // event wires
  logic                         out_off;
  logic                         auto_rpt;
  logic                         tmg_rst;
  logic                         spread;
  logic                         off_clear;
  logic                         restart_load;
  logic                         period_end;
  logic                         restart_rpt;
  logic                         restart_any;
  logic                         copy_stage;
  logic [`SSPWM_STAT_EDGE_W-1:0] edge_count;
  logic [`SSPWM_DATA_W-1:0]     status_word;
  logic [`SSPWM_DATA_W-1:0]     gs_word;
  logic [`SSPWM_DATA_W-1:0]     ctrl_word;

  // two flip-flops before the pin is looked at, third for edge detect
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      gclk_meta_reg <= 1'b0;
      gclk_sync_reg <= 1'b0;
      gclk_prev_reg <= 1'b0;
    end
    else
    begin
      gclk_meta_reg <= i_grayscale_clock;
      gclk_sync_reg <= gclk_meta_reg;
      gclk_prev_reg <= gclk_sync_reg;
    end
  end

  // one-cycle enable per rising grayscale clock edge
  assign gs_tick = gclk_sync_reg & ~gclk_prev_reg;

  // address decode; gs words sit in page 0x40..0x7c
  assign ctrl_sel   = (i_addr == `SSPWM_CTRL_ADDR);
  assign status_sel = (i_addr == `SSPWM_STATUS_ADDR);
  assign load_sel   = (i_addr == `SSPWM_LOAD_ADDR);
  assign gs_idx     = i_addr[CH_W+1:2];
  assign gs_sel     = (i_addr[`SSPWM_ADDR_W-1:CH_W+2] == `SSPWM_GS_PAGE)
                    & (i_addr[1:0] == 2'h0)
                    & ({1'b0, gs_idx} < (CH_W+1)'(N_CH));
  assign ctrl_wr    = i_wr & ctrl_sel;
  assign load_wr    = i_wr & load_sel;
  assign gs_wr      = i_wr & gs_sel;

  // control bits
  assign out_off  = ctrl_reg[`SSPWM_CTRL_OFF];
  assign auto_rpt = ctrl_reg[`SSPWM_CTRL_RPT];
  assign tmg_rst  = ctrl_reg[`SSPWM_CTRL_TMG];
  assign spread   = ctrl_reg[`SSPWM_CTRL_SPREAD];
  assign ctrl_next = ctrl_wr ? i_wdata[`SSPWM_CTRL_W-1:0] : ctrl_reg;

  // output-off going from one to zero arms a period
  assign off_clear    = ctrl_wr & out_off & ~i_wdata[`SSPWM_CTRL_OFF];
  // load strobe with timing restart acts like an output-off pulse
  assign restart_load = load_wr & tmg_rst;
  // 4096th edge of a running period
  assign period_end   = gs_tick & (state_reg == sspwm_pkg::SSPWM_RUN)
                      & (idx_reg == `SSPWM_PERIOD_LAST);
  assign restart_rpt  = period_end & auto_rpt;
  assign restart_any  = off_clear | restart_load | restart_rpt;
  // second stage follows first while off, on restart and at period end
  assign copy_stage   = out_off | restart_load | period_end;

  // state sequencing; output-off overrides everything
  always_comb
  begin
    state_next = state_reg;
    if (out_off && !off_clear)
    begin
      state_next = sspwm_pkg::SSPWM_IDLE;
    end
    else if (restart_any)
    begin
      state_next = sspwm_pkg::SSPWM_ARMED;
    end
    else if (gs_tick)
    begin
      case (state_reg)
        sspwm_pkg::SSPWM_ARMED:
        begin
          state_next = sspwm_pkg::SSPWM_RUN;
        end
        sspwm_pkg::SSPWM_RUN:
        begin
          if (idx_reg == `SSPWM_PERIOD_LAST)
          begin
            state_next = sspwm_pkg::SSPWM_IDLE;
          end
        end
        default:
        begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // counter starts from zero on first edge, held at zero otherwise
  assign idx_next = (state_next != sspwm_pkg::SSPWM_RUN) ? '0 :
                    ((state_reg == sspwm_pkg::SSPWM_RUN) && gs_tick)
                    ? idx_reg + 12'h001 : idx_reg;

  // one decision per channel from its own second-stage value
  generate
    for (genvar c = 0; c < N_CH; c++)
    begin : g_chan
      sspwm_channel u_chan (
        .i_value  (gs2_reg[c]),
        .i_index  (idx_next),
        .i_spread (spread),
        .o_on     (chan_on[c])
      );
    end
  endgenerate

  // all sinks off outside a running period
  assign sink_next = (state_next == sspwm_pkg::SSPWM_RUN) ? chan_on : '0;

  // sequencer registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_reg  <= sspwm_pkg::SSPWM_IDLE;
      idx_reg    <= '0;
      sink_reg   <= '0;
      active_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      idx_reg    <= idx_next;
      sink_reg   <= sink_next;
      active_reg <= (state_next == sspwm_pkg::SSPWM_RUN);
    end
  end

  // control register; output-off comes up set so nothing lights
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ctrl_reg <= `SSPWM_CTRL_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // first stage written by software, second stage used for display;
  // a write in the same cycle as a copy reaches second stage next copy
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      for (int c = 0; c < N_CH; c++)
      begin
        gs1_reg[c] <= '0;
        gs2_reg[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < N_CH; c++)
      begin
        if (gs_wr && (gs_idx == CH_W'(c)))
        begin
          gs1_reg[c] <= i_wdata[`SSPWM_GS_W-1:0];
        end
        if (copy_stage)
        begin
          gs2_reg[c] <= gs1_reg[c];
        end
      end
    end
  end

  // readback words; edge count shows zero while held
  assign edge_count  = (state_reg == sspwm_pkg::SSPWM_RUN)
                     ? {1'b0, idx_reg} + 13'h0001 : '0;
  assign status_word = {14'h0000,
                        (state_reg == sspwm_pkg::SSPWM_ARMED),
                        (state_reg == sspwm_pkg::SSPWM_RUN),
                        3'h0,
                        edge_count};
  assign gs_word     = {20'h00000, gs1_reg[gs_idx]};
  assign ctrl_word   = {28'h0000000, ctrl_reg};

  // read mux; unmapped addresses and the load word read zero
  assign rdata_next = !i_rd      ? '0 :
                      ctrl_sel   ? ctrl_word :
                      status_sel ? status_word :
                      gs_sel     ? gs_word : '0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign o_rdata               = rdata_reg;
  assign o_channel_sink_output = sink_reg;
  assign o_period_active       = active_reg;
endmodule

// file: tb_top.sv
// self-checking bench of the spread-spectrum pwm sequencer
`timescale 1ns/100ps
`include "sspwm_defines.svh"
module tb_top;
  logic        i_clk;
  logic        i_rstn;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        gs_pin;
  logic [15:0] o_channel_sink_output;
  logic        o_period_active;
  logic        gs_en;
  logic [1:0]  gs_half;
  logic [11:0] gs [16];
  logic [11:0] gs_nx [16];
  logic        conv;
  int          num_errors;
  int          n_checks;
  int          seed;
  int          step;
  sspwm_sequencer #(.N_CH(16)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_grayscale_clock(gs_pin),
    .o_channel_sink_output(o_channel_sink_output), .o_period_active(o_period_active));
  sspwm_grayscale_clock_model u_ctl (.i_clk(i_clk), .i_en(gs_en), .i_half(gs_half), .o_grayscale_clock(gs_pin));
  // clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // strobe lowered a cycle later so no signal is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    #1 i_wr <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    #1 i_rd <= 1'b0;
    chk_reg("rdata", e, o_rdata);
    @(posedge i_clk);
    #1;
  endtask
  // expected {active, sinks} for period index p
  function automatic logic [16:0] exp_out(input logic [11:0] p);
    logic [4:0] r;
    exp_out[16] = 1'b1;
    r = {p[7], p[8], p[9], p[10], p[11]};
    for (int k = 0; k < 16; k++)
      exp_out[k] = conv ? (p < gs[k]) : (p[6:0] < (gs[k] >> 5) + (r < gs[k][4:0]));
  endfunction
  // one sample per grayscale period; optional control write at index 5
  task automatic run(input int n, input logic [3:0] cv);
    int w;
    w = 0;
    while (!o_period_active && w < 40)
    begin
      @(posedge i_clk);
      #1 w++;
    end
    for (int p = 0; p < n; p++)
    begin
      chk_pin("sinks", exp_out(12'(p)), {o_period_active, o_channel_sink_output});
      if (cv != 4'h0 && p == 5)
      begin
        wr(`SSPWM_CTRL_ADDR, {28'h0, cv});
        repeat (step - 2) @(posedge i_clk);
      end
      else
        repeat (step) @(posedge i_clk);
      #1;
    end
  endtask
  // watchdog sized from about 70k cycles of tests
  initial
  begin
    #(90000 * 50);
    num_errors++;
    final_report;
  end
  initial
  begin
    seed = 23554;
    num_errors = 0;
    n_checks = 0;
    i_rstn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    gs_en = 1'b0;
    gs_half = 2'h2;
    conv = 1'b0;
    step = 4;
    gs = '{12'h000, 12'h001, 12'h020, 12'h040, 12'hfff, 12'hffe, 12'h002, 12'h021,
           12'h03f, 12'h041, 12'hfe1, 12'hedf, 12'h0, 12'h0, 12'h0, 12'h0};
    for (int k = 12; k < 16; k++)
      gs[k] = 12'($random(seed));
    repeat (4) @(posedge i_clk);
    #1 i_rstn <= 1'b1;
    rd(`SSPWM_CTRL_ADDR, 32'h9);
    rd(`SSPWM_STATUS_ADDR, 32'h0);
    rd(8'hfc, 32'h0);
    for (int k = 0; k < 16; k++)
      wr(8'h40 + 8'(4 * k), {20'h0, gs[k]});
    for (int k = 0; k < 16; k++)
      rd(8'h40 + 8'(4 * k), {20'h0, gs[k]});
    $display("registers done");
    wr(`SSPWM_CTRL_ADDR, 32'h8);
    gs_en <= 1'b1;
    run(4095, 4'h0);
    chk_pin("end", 17'h0, {o_period_active, o_channel_sink_output});
    repeat (40) @(posedge i_clk);
    #1 chk_pin("idle", 17'h0, {o_period_active, o_channel_sink_output});
    $display("single period done");
    gs_en <= 1'b0;
    wr(`SSPWM_CTRL_ADDR, 32'h9);
    wr(`SSPWM_CTRL_ADDR, 32'ha);
    // new values wait in first stage until the period end
    for (int k = 0; k < 16; k++)
    begin
      gs_nx[k] = 12'($random(seed) + k);
      wr(8'h40 + 8'(4 * k), {20'h0, gs_nx[k]});
    end
    gs_en <= 1'b1;
    run(4095, 4'h0);
    chk_pin("gap", 17'h0, {o_period_active, o_channel_sink_output});
    gs = gs_nx;
    run(4095, 4'h0);
    $display("repeat periods done");
    // conventional mode, first part of a single period
    wr(`SSPWM_CTRL_ADDR, 32'h1);
    wr(`SSPWM_CTRL_ADDR, 32'h0);
    conv = 1'b1;
    run(300, 4'h0);
    $display("conventional done");
    // timing restart by load strobe with fresh values
    wr(`SSPWM_CTRL_ADDR, 32'hc);
    for (int k = 0; k < 16; k++)
    begin
      gs_nx[k] = 12'($random(seed));
      wr(8'h40 + 8'(4 * k), {20'h0, gs_nx[k]});
    end
    wr(`SSPWM_LOAD_ADDR, 32'h1);
    conv = 1'b0;
    gs = gs_nx;
    run(4095, 4'h0);
    chk_pin("load end", 17'h0, {o_period_active, o_channel_sink_output});
    $display("load restart done");
    final_report;
  end
endmodule
